//--- hdl/cassette_pkg.sv
// constants, field layout and carrier types of the cassette status bank
package cassette_pkg;

  //////////////////////////////////////////////////////////////////////
  // register offsets on the plain port
  localparam logic [7:0] OFF_XFER_CTRL = 8'h0E; // cassette_transfer_control
  localparam logic [7:0] OFF_SIZE      = 8'h0F; // program_size_codes
  localparam logic [7:0] OFF_INTEG     = 8'h10; // memory_integrity_flags
  localparam logic [7:0] OFF_T_HM      = 8'h11; // time_hour_minute
  localparam logic [7:0] OFF_T_MS      = 8'h12; // time_minute_second
  localparam logic [7:0] OFF_T_DH      = 8'h13; // time_date_hour
  localparam logic [7:0] OFF_T_YM      = 8'h14; // time_year_month
  localparam logic [7:0] OFF_T_WD      = 8'h15; // time_weekday_control
  localparam logic [7:0] OFF_CAS_TYPE  = 8'h16; // cassette type code

  //////////////////////////////////////////////////////////////////////
  // bit positions
  localparam int B_UPLOAD  = 0;  // cpu to cassette start
  localparam int B_DNLOAD  = 1;  // cassette to cpu start
  localparam int B_CMP     = 2;  // compare active
  localparam int B_CMP_RES = 3;  // compare result
  localparam int B_E_MODE  = 12; // refused in programming mode
  localparam int B_E_PROT  = 13; // destination write-protected
  localparam int B_E_CAP   = 14; // destination too small
  localparam int B_E_EMPTY = 15; // cassette holds no program
  localparam int B_SETUP   = 11; // setup area reinitialised
  localparam int B_PINV    = 12; // program invalid
  localparam int B_TABLE   = 13; // instruction table reinitialised
  localparam int B_HOT     = 14; // cassette added under power
  localparam int B_AUTO    = 15; // auto-load failed
  localparam int B_ADJ30   = 13; // 30-second adjust (write one)

  //////////////////////////////////////////////////////////////////////
  // codes
  localparam logic [7:0] SZ_NONE  = 8'h00; // no program
  localparam logic [7:0] SZ_SMALL = 8'h04; // under 3.2K words
  localparam logic [7:0] SZ_LARGE = 8'h08; // under 7.2K words
  localparam logic [3:0] CT_NONE  = 4'h0;  // no cassette
  localparam logic [3:0] CT_EE4K  = 4'h1;  // 4K-word eeprom
  localparam logic [3:0] CT_EE8K  = 4'h2;  // 8K-word eeprom
  localparam logic [3:0] CT_EPROM = 4'h4;  // eprom
  localparam logic [15:0] RST_WORD = 16'h0000; // reset value of words

  // transfer operation code to the cassette engine
  typedef enum logic [1:0] {
    OP_UPLOAD  = 2'b00,
    OP_DNLOAD  = 2'b01,
    OP_COMPARE = 2'b10
  } xfer_op_t;

  // cassette status seen at the socket
  typedef struct packed {
    logic       present;     // cassette fitted
    logic       clock_avail; // cassette carries a clock
    logic       wprot;       // write protect switch
    logic [3:0] ctype;       // cassette type code
    logic [7:0] size;        // program size code in cassette
  } cas_stat_t;

  // time of day from the cassette clock, BCD bytes
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtc_t;

  // answer of the cassette transfer engine
  typedef struct packed {
    logic done; // level, held until request drops
    logic ok;   // operation completed without fault
    logic diff; // compare found a difference
  } xfer_ans_t;

endpackage : cassette_pkg

//--- hdl/cassette_transfer_status_bank.sv
// cassette transfer control, size codes, integrity flags and time words
//
// The plain strobed port was left to the implementer.
module cassette_transfer_status_bank (
  input  wire logic                   clk,          // 100 MHz scan clock
  input  wire logic                   rst_n,        // async reset
  input  wire logic                   ce,           // clock enable
  input  wire logic [7:0]             addr,         // register offset
  input  wire logic [15:0]            wdata,        // write data
  input  wire logic                   wr,           // write strobe
  input  wire logic                   rd,           // read strobe
  output logic      [15:0]            rdata,        // read data
  input  wire logic [2:0]             force_bits,   // tool force on 0..2
  input  wire logic                   prog_mode,    // programming mode
  input  wire logic [7:0]             cpu_size,     // cpu program size
  input  wire logic                   powerup,      // power-up pulse
  input  wire logic                   setup_bad,    // setup checksum fail
  input  wire logic                   um_bad,       // program checksum fail
  input  wire logic                   bad_instr,    // improper instruction
  input  wire logic                   table_bad,    // table checksum fail
  input  wire logic                   autoload_pin, // auto-load switch
  input  wire cassette_pkg::cas_stat_t cas_pin,     // socket status
  input  wire cassette_pkg::rtc_t      rtc_pin,     // cassette clock
  input  wire cassette_pkg::xfer_ans_t ans_pin,     // engine answer
  output logic                        xfer_req,     // engine request
  output cassette_pkg::xfer_op_t      xfer_op,      // engine operation
  output logic                        setup_restore, // restore setup
  output logic                        table_restore, // restore table
  output logic                        adj30         // 30 s adjust pulse
);

  //////////////////////////////////////////////////////////////////////
  // parameters
  localparam logic [7:0] CPU_CAP = cassette_pkg::SZ_LARGE; // cpu capacity

  // states of the transfer sequencer
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CHECK = 3'b001,
    S_REQ   = 3'b010,
    S_DROP  = 3'b011
  } st_t;

  //////////////////////////////////////////////////////////////////////
  // synchronisers for pins from the cassette side
  cassette_pkg::cas_stat_t cas_s1_ff, cas_ff;   // socket status
  cassette_pkg::rtc_t      rtc_s1_ff, rtc_ff;   // time of day
  cassette_pkg::xfer_ans_t ans_s1_ff, ans_ff;   // engine answer
  logic                    al_s1_ff, al_ff;     // auto-load switch

  // two flip-flops before any logic reads a pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cas_s1_ff <= '0;
      cas_ff    <= '0;
      rtc_s1_ff <= '0;
      rtc_ff    <= '0;
      ans_s1_ff <= '0;
      ans_ff    <= '0;
      al_s1_ff  <= 1'b0;
      al_ff     <= 1'b0;
    end else if (ce) begin
      cas_s1_ff <= cas_pin;
      cas_ff    <= cas_s1_ff;
      rtc_s1_ff <= rtc_pin;
      rtc_ff    <= rtc_s1_ff;
      ans_s1_ff <= ans_pin;
      ans_ff    <= ans_s1_ff;
      al_s1_ff  <= autoload_pin;
      al_ff     <= al_s1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state
  st_t                   st_ff, nxt_st;       // sequencer state
  logic [2:0]            start_ff, nxt_start; // bits 0..2
  logic                  res_ff, nxt_res;     // compare result
  logic [3:0]            err_ff, nxt_err;     // bits 12..15
  logic [4:0]            integ_ff, nxt_integ; // bits 11..15
  logic                  auto_ff, nxt_auto;   // running auto-load
  logic                  pwr_ff;              // power-up seen
  logic                  pres_ff;             // last presence
  logic [2:0]            frc_ff;              // last force bits
  cassette_pkg::xfer_op_t op_ff, nxt_op;      // operation in flight
  logic [15:0]           rdata_ff, nxt_rdata; // read data

  //////////////////////////////////////////////////////////////////////
  // decode
  wire wr_ctrl  = wr && addr == cassette_pkg::OFF_XFER_CTRL; // ctrl write
  wire wr_wd    = wr && addr == cassette_pkg::OFF_T_WD;      // adj write
  wire idle     = st_ff == S_IDLE;                           // no job
  wire [2:0] wr_set = wr_ctrl ? wdata[2:0] : 3'b000;        // bits to set
  wire [2:0] frc_rise = force_bits & ~frc_ff;               // new force
  wire [2:0] new_req  = (wr_set | frc_rise) & {3{idle}};
  wire auto_go  = idle && powerup && al_ff;                  // auto-load
  wire any_req  = |new_req || auto_go;                       // accepted
  wire [2:0] start_vis = start_ff | force_bits;
  wire hot_ins  = pwr_ff && cas_ff.present && !pres_ff;
  wire clk_ok   = cas_ff.present && cas_ff.clock_avail;

  // refusal checks for the operation in flight
  wire is_up    = op_ff == cassette_pkg::OP_UPLOAD;
  wire is_dn    = op_ff == cassette_pkg::OP_DNLOAD;
  wire is_cmp   = op_ff == cassette_pkg::OP_COMPARE;
  wire no_prog  = !cas_ff.present ||
                  cas_ff.size == cassette_pkg::SZ_NONE;
  wire up_prot  = !cas_ff.present || cas_ff.wprot ||
                  cas_ff.ctype == cassette_pkg::CT_EPROM;
  wire up_cap   = cas_ff.ctype == cassette_pkg::CT_EE4K &&
                  cpu_size > cassette_pkg::SZ_SMALL;
  wire dn_cap   = cas_ff.size > CPU_CAP;

  //////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    nxt_st    = st_ff;
    nxt_start = start_ff;
    nxt_res   = res_ff;
    nxt_err   = err_ff;
    nxt_op    = op_ff;
    nxt_auto  = auto_ff;
    case (st_ff)
      S_IDLE: begin
        if (any_req) begin
          nxt_err   = 4'h0;
          nxt_start = start_ff | new_req;
          nxt_auto  = auto_go && !(|new_req);
          nxt_st    = S_CHECK;
          // upload wins over download, download over compare
          if (new_req[cassette_pkg::B_UPLOAD])
            nxt_op = cassette_pkg::OP_UPLOAD;
          else if (new_req[cassette_pkg::B_DNLOAD] || nxt_auto)
            nxt_op = cassette_pkg::OP_DNLOAD;
          else begin
            nxt_op  = cassette_pkg::OP_COMPARE;
            nxt_res = 1'b0;
          end
        end
      end
      S_CHECK: begin
        nxt_st = S_REQ;
        if (is_cmp) begin
          if (no_prog) begin
            nxt_res = 1'b1;
            nxt_st  = S_IDLE;
          end
        end else if (prog_mode && !auto_ff) begin
          nxt_err[cassette_pkg::B_E_MODE - 12] = 1'b1;
          nxt_st = S_IDLE;
        end else if (is_dn && no_prog) begin
          nxt_err[cassette_pkg::B_E_EMPTY - 12] = 1'b1;
          nxt_st = S_IDLE;
        end else if (is_up && up_prot) begin
          nxt_err[cassette_pkg::B_E_PROT - 12] = 1'b1;
          nxt_st = S_IDLE;
        end else if ((is_up && up_cap) || (is_dn && dn_cap)) begin
          nxt_err[cassette_pkg::B_E_CAP - 12] = 1'b1;
          nxt_st = S_IDLE;
        end
      end
      S_REQ: begin
        // wait for the engine to finish
        if (ans_ff.done) begin
          if (is_cmp)
            nxt_res = ans_ff.diff || !ans_ff.ok;
          nxt_st = S_DROP;
        end
      end
      S_DROP: begin
        // wait for the engine to release its answer
        if (!ans_ff.done)
          nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
    // leaving the job: self-clear the start or compare bit
    if (!idle && nxt_st == S_IDLE) begin
      nxt_start = 3'b000;
      nxt_auto  = 1'b0;
    end
  end

  // auto-load failure: refused, or engine fault taken while done stands;
  // ok means nothing once done has dropped, so it is not read then
  wire auto_fail = auto_ff &&
                   ((st_ff == S_CHECK && nxt_st == S_IDLE) ||
                    (st_ff == S_REQ && ans_ff.done && !ans_ff.ok));

  //////////////////////////////////////////////////////////////////////
  // integrity flags, set only, event wins
  always_comb begin
    nxt_integ = integ_ff;
    if (setup_bad) nxt_integ[cassette_pkg::B_SETUP - 11] = 1'b1;
    if (um_bad || bad_instr)
      nxt_integ[cassette_pkg::B_PINV - 11] = 1'b1;
    if (table_bad) nxt_integ[cassette_pkg::B_TABLE - 11] = 1'b1;
    if (hot_ins)   nxt_integ[cassette_pkg::B_HOT - 11] = 1'b1;
    if (auto_fail) nxt_integ[cassette_pkg::B_AUTO - 11] = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // read mux
  wire [15:0] w_ctrl = {err_ff, 8'h00, res_ff, start_vis};
  wire [15:0] w_size = {cpu_size, cas_ff.present ?
                        cas_ff.size : cassette_pkg::SZ_NONE};
  wire [15:0] w_integ = {integ_ff, 11'h000};
  wire [15:0] w_hm = clk_ok ? {rtc_ff.hour, rtc_ff.minute} : 16'h0000;
  wire [15:0] w_ms = clk_ok ? {rtc_ff.minute, rtc_ff.second} : 16'h0000;
  wire [15:0] w_dh = clk_ok ? {rtc_ff.date, rtc_ff.hour} : 16'h0000;
  wire [15:0] w_ym = clk_ok ? {rtc_ff.year, rtc_ff.month} : 16'h0000;
  wire [15:0] w_wd = clk_ok ? {8'h00, rtc_ff.dow} : 16'h0000;
  wire [15:0] w_ct = {12'h000, cas_ff.present ?
                      cas_ff.ctype : cassette_pkg::CT_NONE};

  always_comb begin
    case (addr)
      cassette_pkg::OFF_XFER_CTRL: nxt_rdata = w_ctrl;
      cassette_pkg::OFF_SIZE:      nxt_rdata = w_size;
      cassette_pkg::OFF_INTEG:     nxt_rdata = w_integ;
      cassette_pkg::OFF_T_HM:      nxt_rdata = w_hm;
      cassette_pkg::OFF_T_MS:      nxt_rdata = w_ms;
      cassette_pkg::OFF_T_DH:      nxt_rdata = w_dh;
      cassette_pkg::OFF_T_YM:      nxt_rdata = w_ym;
      cassette_pkg::OFF_T_WD:      nxt_rdata = w_wd;
      cassette_pkg::OFF_CAS_TYPE:  nxt_rdata = w_ct;
      default:                     nxt_rdata = 16'h0000;     // unmapped
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= S_IDLE;
      start_ff <= 3'b000;
      res_ff   <= 1'b0;
      err_ff   <= 4'h0;
      integ_ff <= 5'h00;
      auto_ff  <= 1'b0;
      op_ff    <= cassette_pkg::OP_UPLOAD;
      rdata_ff <= cassette_pkg::RST_WORD;
    end else if (ce) begin
      st_ff    <= nxt_st;
      start_ff <= nxt_start;
      res_ff   <= nxt_res;
      err_ff   <= nxt_err;
      integ_ff <= nxt_integ;
      auto_ff  <= nxt_auto;
      op_ff    <= nxt_op;
      rdata_ff <= rd ? nxt_rdata : cassette_pkg::RST_WORD;
    end
  end

  // edge trackers and one-cycle pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff        <= 1'b0;
      pres_ff       <= 1'b0;
      frc_ff        <= 3'b000;
      setup_restore <= 1'b0;
      table_restore <= 1'b0;
      adj30         <= 1'b0;
    end else if (ce) begin
      pwr_ff        <= pwr_ff | powerup;
      pres_ff       <= cas_ff.present;
      frc_ff        <= force_bits;
      setup_restore <= setup_bad;
      table_restore <= table_bad;
      adj30         <= wr_wd && wdata[cassette_pkg::B_ADJ30];
    end
  end

  // engine request held through the wait
  assign xfer_req = st_ff == S_REQ;
  assign xfer_op  = op_ff;
  assign rdata    = rdata_ff;

endmodule : cassette_transfer_status_bank

//--- tb/cassette_model.sv
// behavioural cassette transfer engine at the far side of the bank
module cassette_model (
  input  wire logic                   clk,      // scan clock
  input  wire logic                   rst_n,    // async reset
  input  wire logic                   xfer_req, // engine request
  input  wire cassette_pkg::xfer_op_t xfer_op,  // requested operation
  input  wire logic                   diff_sel, // compare finds difference
  input  wire logic                   fail_sel, // operation fails
  output cassette_pkg::xfer_ans_t     ans       // answer to the bank
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_ff; // copy time counter
  logic       done_ff; // finish level
  logic       tgl_ff;  // junk pattern for idle lines
  //////////////////////////////////////////////////////////////////////
  // slow copy, finish held until the request drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 5'h00;
      done_ff <= 1'h0;
      tgl_ff  <= 1'h0;
    end else begin
      tgl_ff <= ~tgl_ff;
      if (!xfer_req) begin // release after request drops
        cnt_ff  <= 5'h00;
        done_ff <= 1'h0;
      end else if (cnt_ff == 5'h0C) begin // copy over
        done_ff <= 1'h1;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end
  // result lines carry junk while no finish is shown
  assign ans.done = done_ff;
  assign ans.ok   = done_ff ? !fail_sel : tgl_ff;
  assign ans.diff = done_ff ? (diff_sel && xfer_op == cassette_pkg::OP_COMPARE)
                            : ~tgl_ff;
endmodule : cassette_model

//--- tb/cassette_checker.sv
// port assertions of the cassette status bank
module cassette_checker (
  input wire logic                    clk,           // scan clock
  input wire logic                    rst_n,         // async reset
  input wire logic                    ce,            // clock enable
  input wire logic [7:0]              addr,          // register offset
  input wire logic                    rd,            // read strobe
  input wire logic [15:0]             rdata,         // read data
  input wire logic                    prog_mode,     // programming mode
  input wire logic [7:0]              cpu_size,      // cpu size code
  input wire logic                    autoload_pin,  // auto-load switch
  input wire logic                    setup_bad,     // setup fail
  input wire logic                    table_bad,     // table fail
  input wire logic                    um_bad,        // program fail
  input wire cassette_pkg::xfer_ans_t ans_pin,       // engine answer
  input wire logic                    xfer_req,      // engine request
  input wire cassette_pkg::xfer_op_t  xfer_op,       // engine operation
  input wire logic                    setup_restore, // restore setup
  input wire logic                    table_restore  // restore table
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  // program fault then a read of the integrity word
  sequence s_bad_rd;
    um_bad ##2 (rd && addr == cassette_pkg::OFF_INTEG);
  endsequence
  // programming mode held with auto-load off
  sequence s_prog;
    (prog_mode && !autoload_pin) [*4];
  endsequence
  setup_restore_a: assert property (ce && setup_bad |=> setup_restore)
    else $error("setup restore pulse missing");
  table_restore_a: assert property (ce && table_bad |=> table_restore)
    else $error("table restore pulse missing");
  size_read_a: assert property (rd && addr == cassette_pkg::OFF_SIZE
    |=> rdata[15:8] == $past(cpu_size)) else $error("cpu size byte wrong");
  prog_refuse_a: assert property (s_prog |-> !$rose(xfer_req))
    else $error("request issued in programming mode");
  req_drop_a: assert property (ans_pin.done |-> ##[0:6] !xfer_req)
    else $error("request not dropped after finish");
  op_stable_a: assert property (xfer_req && $past(xfer_req)
    |-> $stable(xfer_op)) else $error("operation changed mid request");
  weekday_hi_a: assert property (rd && addr == cassette_pkg::OFF_T_WD
    |=> rdata[15:8] == 8'h00) else $error("weekday upper byte not zero");
  invalid_flag_a: assert property (s_bad_rd |=> rdata[12])
    else $error("program invalid flag not set");
endmodule : cassette_checker
bind cassette_transfer_status_bank cassette_checker i_chk (.clk, .rst_n,
  .ce, .addr, .rd, .rdata, .prog_mode, .cpu_size, .autoload_pin, .setup_bad,
  .table_bad, .um_bad, .ans_pin, .xfer_req, .xfer_op, .setup_restore,
  .table_restore);

//--- tb/tb_top.sv
// self-checking bench for the cassette status bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, wr, rd, powerup, prog_mode, autoload_pin;
  logic setup_bad, um_bad, bad_instr, table_bad, diff_sel, fail_sel;
  logic xfer_req, setup_restore, table_restore, adj30;
  logic [7:0]  addr, cpu_size;
  logic [15:0] wdata, rdata;
  logic [2:0]  force_bits;
  cassette_pkg::cas_stat_t cas;
  cassette_pkg::rtc_t      rtc;
  cassette_pkg::xfer_ans_t ans;
  cassette_pkg::xfer_op_t  xfer_op;
  int n_errors, n_checks;
  cassette_transfer_status_bank i_cassette_transfer_status_bank (.clk,
    .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .force_bits, .prog_mode,
    .cpu_size, .powerup, .setup_bad, .um_bad, .bad_instr, .table_bad,
    .autoload_pin, .cas_pin(cas), .rtc_pin(rtc), .ans_pin(ans), .xfer_req,
    .xfer_op, .setup_restore, .table_restore, .adj30);
  cassette_model i_cassette_model (.clk, .rst_n, .xfer_req, .xfer_op,
    .diff_sel, .fail_sel, .ans);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  // compare, bus cycles and waits
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task rd_word(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd_word
  task rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd_word(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask : rd_chk
  task wait_idle; // poll start bits, bounded
    logic [15:0] v;
    repeat (100) begin
      rd_word(cassette_pkg::OFF_XFER_CTRL, v);
      if (v[2:0] === 3'h0) return;
    end
    n_errors++;
    $display("[ERR] ctrl never idle");
    tally_and_finish();
  endtask : wait_idle
  task wait_req; // request seen high then low, bounded
    logic seen;
    seen = 1'h0;
    repeat (200) begin
      @(negedge clk);
      if (xfer_req === 1'h1) seen = 1'h1;
      else if (seen) begin
        @(posedge clk);
        return;
      end
    end
    n_errors++;
    $display("[ERR] request never completed");
    tally_and_finish();
  endtask : wait_req
  task job(input logic [15:0] cmd, input logic [15:0] exp);
    wr_reg(cassette_pkg::OFF_XFER_CTRL, cmd);
    wait_idle();
    rd_chk(cassette_pkg::OFF_XFER_CTRL, exp);
  endtask : job
  //////////////////////////////////////////////////////////////////////
  // scenarios
  task t_size; // size codes, read-only word, unmapped place
    logic [7:0] code [3];
    code = '{8'h00, 8'h04, 8'h08};
    foreach (code[i]) begin
      cas.size <= code[i];
      cpu_size <= code[2 - (i % 2) * 1];
      repeat (4) @(posedge clk);
      rd_chk(cassette_pkg::OFF_SIZE, {cpu_size, code[i]});
    end
    wr_reg(cassette_pkg::OFF_SIZE, 16'hFFFF);
    rd_chk(cassette_pkg::OFF_SIZE, 16'h0808);
    rd_chk(8'h30, 16'h0000);
    ce <= 1'h0; // frozen: the start write must be lost
    wr_reg(cassette_pkg::OFF_XFER_CTRL, 16'h0001);
    ce <= 1'h1;
    rd_chk(cassette_pkg::OFF_XFER_CTRL, 16'h0000);
    cpu_size <= 8'h04;
  endtask : t_size
  task t_jobs; // transfers, compares and refusals
    job(16'h0001, 16'h0000);
    job(16'h0002, 16'h0000);
    diff_sel <= 1'h1;
    job(16'h0004, 16'h0008);
    diff_sel <= 1'h0;
    wr_reg(cassette_pkg::OFF_XFER_CTRL, 16'h0004);
    rd_chk(cassette_pkg::OFF_XFER_CTRL, 16'h0004);
    wait_idle();
    rd_chk(cassette_pkg::OFF_XFER_CTRL, 16'h0000);
    fail_sel <= 1'h1;
    job(16'h0004, 16'h0008);
    fail_sel  <= 1'h0;
    job(16'h0004, 16'h0000);
    prog_mode <= 1'h1;
    job(16'h0001, 16'h1000);
    prog_mode <= 1'h0;
    cas.wprot <= 1'h1;
    job(16'h0001, 16'h2000);
    cas.wprot <= 1'h0;
    cas.ctype <= cassette_pkg::CT_EE4K;
    cpu_size  <= 8'h08;
    job(16'h0001, 16'h4000);
    cas.ctype <= cassette_pkg::CT_EE8K;
    cas.size  <= 8'h00;
    job(16'h0002, 16'h8000);
    cas.size <= 8'h08;
  endtask : t_jobs
  task t_force; // forced start bit stays up until released
    force_bits <= 3'h1;
    wait_req();
    repeat (8) @(posedge clk);
    rd_chk(cassette_pkg::OFF_XFER_CTRL, 16'h0001);
    force_bits <= 3'h0;
    rd_chk(cassette_pkg::OFF_XFER_CTRL, 16'h0000);
  endtask : t_force
  task t_integ; // sticky integrity flags
    bad_instr <= 1'h1;
    @(posedge clk);
    bad_instr <= 1'h0;
    rd_chk(cassette_pkg::OFF_INTEG, 16'h1000);
    {setup_bad, table_bad, um_bad} <= 3'h7;
    @(posedge clk);
    {setup_bad, table_bad, um_bad} <= 3'h0;
    rd_chk(cassette_pkg::OFF_INTEG, 16'h3800);
    cas.present <= 1'h0;
    repeat (4) @(posedge clk);
    cas.present <= 1'h1;
    repeat (4) @(posedge clk);
    rd_chk(cassette_pkg::OFF_INTEG, 16'h7800);
    autoload_pin <= 1'h1;
    fail_sel     <= 1'h1;
    repeat (4) @(posedge clk);
    powerup <= 1'h1;
    @(posedge clk);
    powerup <= 1'h0;
    wait_req();
    autoload_pin <= 1'h0;
    fail_sel     <= 1'h0;
    wait_idle();
    rd_chk(cassette_pkg::OFF_INTEG, 16'hF800);
  endtask : t_integ
  task t_time; // clock words and cassette type codes
    logic [3:0] ct [4];
    ct = '{4'h0, 4'h1, 4'h2, 4'h4};
    wr_reg(cassette_pkg::OFF_T_WD, 16'h2000); // adjust write, bit reads 0
    #1 chk("adj30", {15'h0000, adj30}, 16'h0001);
    rd_chk(cassette_pkg::OFF_T_HM, 16'h2359);
    rd_chk(cassette_pkg::OFF_T_MS, 16'h5958);
    rd_chk(cassette_pkg::OFF_T_DH, 16'h3123);
    rd_chk(cassette_pkg::OFF_T_YM, 16'h2412);
    rd_chk(cassette_pkg::OFF_T_WD, 16'h0006);
    foreach (ct[i]) begin
      cas.ctype <= ct[i];
      repeat (4) @(posedge clk);
      rd_chk(cassette_pkg::OFF_CAS_TYPE, {12'h000, ct[i]});
    end
  endtask : t_time
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ce, rst_n, wr, rd, powerup, prog_mode, autoload_pin} = 7'h40;
    {setup_bad, um_bad, bad_instr, table_bad, diff_sel, fail_sel} = 6'h00;
    {addr, wdata, force_bits, cpu_size} = {8'h00, 16'h0000, 3'h0, 8'h04};
    cas = '{1'h1, 1'h1, 1'h0, cassette_pkg::CT_EE8K, cassette_pkg::SZ_LARGE};
    rtc = '{8'h24, 8'h12, 8'h31, 8'h06, 8'h23, 8'h59, 8'h58};
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    // let the socket status settle first, or presence looks like insertion
    repeat (4) @(posedge clk);
    powerup <= 1'h1;
    @(posedge clk);
    powerup <= 1'h0;
    @(posedge clk);
    t_size();
    t_jobs();
    t_force();
    t_integ();
    t_time();
    tally_and_finish();
  end
endmodule : tb_top
